// ===== common/spl_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef SPL_MAP_SVH
`define SPL_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SPL_OFS_CTRL      8'h00
`define SPL_OFS_ADV       8'h04
`define SPL_OFS_STAT      8'h08

// ----------------------------------------
// control register field positions
// ----------------------------------------
`define SPL_CTRL_RELOAD   15
`define SPL_CTRL_LOOP     14
`define SPL_CTRL_SPEED    13
`define SPL_CTRL_ANEN     12
`define SPL_CTRL_PDOWN    11
`define SPL_CTRL_ISO      10
`define SPL_CTRL_RESTART  9
`define SPL_CTRL_DUPLEX   8

// ----------------------------------------
// advertisement register fields
// ----------------------------------------
`define SPL_ADV_LSB       5
`define SPL_ADV_MSB       8
`define SPL_ADV_SEL       5'h01
`define SPL_ADV_ALL       4'hF
`define SPL_ADV_10ONLY    4'h3

// ----------------------------------------
// strap defaults (weak pull levels) and timing
// ----------------------------------------
`define SPL_DEF_STRAPS    6'h1D
`define SPL_SETTLE        2'h2

`endif

// ===== common/spl_pkg.sv
// types shared by the strap latch design
package spl_pkg;

  // ----------------------------------------
  // sampled strap levels, as seen on the pins
  // ----------------------------------------
  typedef struct packed {
    logic isolate;
    logic speed;
    logic duplex_half;
    logic autoneg;
    logic addr0_unique;
    logic gate_chain_n;
  } spl_strap_t;

  // ----------------------------------------
  // live control state
  // ----------------------------------------
  typedef struct packed {
    logic loopback;
    logic speed_100;
    logic autoneg_en;
    logic power_down;
    logic isolate;
    logic full_duplex;
  } spl_ctrl_t;

  // ----------------------------------------
  // loader states
  // ----------------------------------------
  typedef enum logic [1:0] {
    SPL_WAIT = 2'b00,
    SPL_LOAD = 2'b01,
    SPL_RUN  = 2'b10
  } spl_state_t;

endpackage

// ===== rtl/spl_sync.sv
// two-stage synchroniser for a group of pin levels
`timescale 1ns/1ps
module spl_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1   <= '0;
      pin_sync <= '0;
    end else begin
      stage1   <= pin_in;
      pin_sync <= stage1;
    end
  end

endmodule

// ===== rtl/spl_addr_filter.sv
// station address match with address-zero treatment
`timescale 1ns/1ps
module spl_addr_filter (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       query_valid,
  input  wire logic [4:0] query_addr,
  input  wire logic [4:0] own_addr,
  input  wire logic       addr0_unique,
  output logic            hit,
  output logic            hit_bcast
);

  // address zero is broadcast unless the strap made it unique
  function automatic logic is_bcast(input logic [4:0] a, input logic uniq);
    is_bcast = (a == 5'h00) && !uniq;
  endfunction

  // own address zero only counts when zero is unique
  function automatic logic is_own(input logic [4:0] a, input logic [4:0] own,
                                  input logic uniq);
    is_own = (a == own) && ((a != 5'h00) || uniq);
  endfunction

  // registered verdict, one cycle after the query
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hit       <= 1'b0;
      hit_bcast <= 1'b0;
    end else begin
      hit       <= query_valid && (is_own(query_addr, own_addr, addr0_unique)
                   || is_bcast(query_addr, addr0_unique));
      hit_bcast <= query_valid && is_bcast(query_addr, addr0_unique);
    end
  end

endmodule

// ===== rtl/spl_top.sv
// strap pin latch: samples straps at reset release and seeds control registers
//
// Notes on behaviour
// - all straps except station_address_strap are caught once after reset release; later pin changes ignored.
// - isolate strap high selects isolation, low (default) none.
// - sampled isolate level goes into control bit 10.
// - speed strap high (default) selects 100 Mbps, low 10 Mbps.
// - sampled speed level goes into control bit 13.
// - sampled speed also sets the advertised speed abilities.
// - duplex strap high (default) means half duplex, low full duplex.
// - sampled duplex level sets control bit 8.
// - autoneg strap high (default) enables autoneg, low disables it.
// - sampled autoneg level goes into control bit 12.
// - address-zero strap high makes station address zero our unique address.
// - address-zero strap low (default) makes address zero a broadcast.
// - gate-chain test strap is active low; high (default) keeps it off.
// - address-zero and gate-chain levels live in internal state only.
// - address zero acts as a unique address only with that strap high.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "spl_map.svh"

module spl_top
  import spl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        isolate_strap,
  input  wire logic        speed_strap,
  input  wire logic        duplex_strap,
  input  wire logic        autoneg_enable_strap,
  input  wire logic        addr_zero_unique_strap,
  input  wire logic        gate_chain_strap_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        query_valid,
  input  wire logic [4:0]  query_addr,
  input  wire logic [4:0]  station_address_strap,
  output logic             addr_hit,
  output logic             addr_hit_bcast,
  output logic             ctrl_isolate,
  output logic             ctrl_speed_100,
  output logic             ctrl_full_duplex,
  output logic             ctrl_autoneg_en,
  output logic             ctrl_loopback,
  output logic             ctrl_power_down,
  output logic             an_restart,
  output logic      [3:0]  adv_ability,
  output logic             gate_chain_test_en,
  output logic             straps_loaded
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  spl_strap_t  pins_raw;
  spl_strap_t  pins_sync;
  spl_strap_t  strap_q;
  spl_ctrl_t   ctrl;
  spl_ctrl_t   next_ctrl;
  spl_state_t  state;
  spl_state_t  next_state;
  logic [1:0]  settle_cnt;
  logic [3:0]  next_adv;
  logic        addr0_unique;
  logic        wr_ctrl;
  logic        wr_adv;
  logic        reload_req;
  logic [31:0] next_rdata;

  // ----------------------------------------
  // helpers
  // ----------------------------------------

  // advertised abilities implied by a speed level
  function automatic logic [3:0] adv_from_speed(input logic spd);
    adv_from_speed = spd ? `SPL_ADV_ALL : `SPL_ADV_10ONLY;
  endfunction

  // control state implied by a set of sampled straps
  function automatic spl_ctrl_t ctrl_from_straps(input spl_strap_t s);
    spl_ctrl_t c;
    c             = '0;
    c.isolate     = s.isolate;
    c.speed_100   = s.speed;
    c.full_duplex = !s.duplex_half;
    c.autoneg_en  = s.autoneg;
    c.loopback    = 1'b0;
    c.power_down  = 1'b0;
    return c;
  endfunction

  // control register word as software sees it
  function automatic logic [15:0] ctrl_word(input spl_ctrl_t c,
                                            input logic busy);
    logic [15:0] w;
    w                    = 16'h0000;
    w[`SPL_CTRL_RELOAD]  = busy;
    w[`SPL_CTRL_LOOP]    = c.loopback;
    w[`SPL_CTRL_SPEED]   = c.speed_100;
    w[`SPL_CTRL_ANEN]    = c.autoneg_en;
    w[`SPL_CTRL_PDOWN]   = c.power_down;
    w[`SPL_CTRL_ISO]     = c.isolate;
    w[`SPL_CTRL_DUPLEX]  = c.full_duplex;
    return w;
  endfunction

  // advertisement word with fixed selector field
  function automatic logic [15:0] adv_word(input logic [3:0] a);
    logic [15:0] w;
    w                             = 16'h0000;
    w[`SPL_ADV_MSB:`SPL_ADV_LSB]  = a;
    w[4:0]                        = `SPL_ADV_SEL;
    return w;
  endfunction

  // ----------------------------------------
  // pin synchronisation
  // ----------------------------------------

  // gather strap pins in pin order
  assign pins_raw.isolate      = isolate_strap;
  assign pins_raw.speed        = speed_strap;
  assign pins_raw.duplex_half  = duplex_strap;
  assign pins_raw.autoneg      = autoneg_enable_strap;
  assign pins_raw.addr0_unique = addr_zero_unique_strap;
  assign pins_raw.gate_chain_n = gate_chain_strap_n;

  spl_sync #(
    .WIDTH    ($bits(spl_strap_t))
  ) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .pin_in   (pins_raw),
    .pin_sync (pins_sync)
  );

  // ----------------------------------------
  // loader state machine
  // ----------------------------------------

  // software reload request, honoured only once running
  assign reload_req = wr_ctrl && reg_wdata[`SPL_CTRL_RELOAD];

  // next-state decode
  always_comb begin
    next_state = state;
    case (state)
      SPL_WAIT: begin
        if (settle_cnt == `SPL_SETTLE) begin
          next_state = SPL_LOAD;
        end
      end
      SPL_LOAD: begin
        next_state = SPL_RUN;
      end
      SPL_RUN: begin
        if (reload_req) begin
          next_state = SPL_LOAD;
        end
      end
      default: begin
        next_state = SPL_WAIT;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= SPL_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // settle counter lets the synchroniser fill after release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      settle_cnt <= 2'h0;
    end else if (state == SPL_WAIT && settle_cnt != `SPL_SETTLE) begin
      settle_cnt <= settle_cnt + 2'h1;
    end
  end

  // ----------------------------------------
  // strap snapshot
  // ----------------------------------------

  // caught once per reset, then frozen against pin changes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strap_q <= spl_strap_t'(`SPL_DEF_STRAPS);
    end else if (state == SPL_WAIT && next_state == SPL_LOAD) begin
      strap_q <= pins_sync;
    end
  end

  // internal-only strap state, no register bit shows it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr0_unique       <= 1'b0;
      gate_chain_test_en <= 1'b0;
    end else if (state == SPL_LOAD) begin
      addr0_unique       <= strap_q.addr0_unique;
      gate_chain_test_en <= !strap_q.gate_chain_n;
    end
  end

  // loaded flag rises with the first load and stays
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      straps_loaded <= 1'b0;
    end else if (state == SPL_LOAD) begin
      straps_loaded <= 1'b1;
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------

  // write decode, live only while running
  assign wr_ctrl = reg_wr && (reg_addr == `SPL_OFS_CTRL) && (state == SPL_RUN);
  assign wr_adv  = reg_wr && (reg_addr == `SPL_OFS_ADV) && (state == SPL_RUN);

  // control: strap load wins, otherwise software may rewrite
  always_comb begin
    next_ctrl = ctrl;
    if (state == SPL_LOAD) begin
      next_ctrl = ctrl_from_straps(strap_q);
    end else if (wr_ctrl && !reload_req) begin
      next_ctrl.loopback    = reg_wdata[`SPL_CTRL_LOOP];
      next_ctrl.speed_100   = reg_wdata[`SPL_CTRL_SPEED];
      next_ctrl.autoneg_en  = reg_wdata[`SPL_CTRL_ANEN];
      next_ctrl.power_down  = reg_wdata[`SPL_CTRL_PDOWN];
      next_ctrl.isolate     = reg_wdata[`SPL_CTRL_ISO];
      next_ctrl.full_duplex = reg_wdata[`SPL_CTRL_DUPLEX];
    end
  end

  // control state register, weak-pull defaults until loaded
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= ctrl_from_straps(spl_strap_t'(`SPL_DEF_STRAPS));
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // advertised abilities follow speed strap at load
  always_comb begin
    next_adv = adv_ability;
    if (state == SPL_LOAD) begin
      next_adv = adv_from_speed(strap_q.speed);
    end else if (wr_adv) begin
      next_adv = reg_wdata[`SPL_ADV_MSB:`SPL_ADV_LSB];
    end
  end

  // advertisement register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      adv_ability <= `SPL_ADV_ALL;
    end else begin
      adv_ability <= next_adv;
    end
  end

  // autoneg restart is a one-cycle self-clearing pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      an_restart <= 1'b0;
    end else begin
      an_restart <= wr_ctrl && !reload_req && reg_wdata[`SPL_CTRL_RESTART];
    end
  end

  // ----------------------------------------
  // control outputs
  // ----------------------------------------

  // registered copies of the live control state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_isolate     <= 1'b0;
      ctrl_speed_100   <= 1'b1;
      ctrl_full_duplex <= 1'b0;
      ctrl_autoneg_en  <= 1'b1;
      ctrl_loopback    <= 1'b0;
      ctrl_power_down  <= 1'b0;
    end else begin
      ctrl_isolate     <= next_ctrl.isolate;
      ctrl_speed_100   <= next_ctrl.speed_100;
      ctrl_full_duplex <= next_ctrl.full_duplex;
      ctrl_autoneg_en  <= next_ctrl.autoneg_en;
      ctrl_loopback    <= next_ctrl.loopback;
      ctrl_power_down  <= next_ctrl.power_down;
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------

  // read mux, unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `SPL_OFS_CTRL: begin
          next_rdata = {16'h0000, ctrl_word(ctrl, state != SPL_RUN)};
        end
        `SPL_OFS_ADV: begin
          next_rdata = {16'h0000, adv_word(adv_ability)};
        end
        `SPL_OFS_STAT: begin
          next_rdata = {24'h00_0000, strap_q.isolate, strap_q.speed,
                        strap_q.duplex_half, strap_q.autoneg,
                        straps_loaded, 1'b0, state};
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // station address filter
  // ----------------------------------------

  // address zero handling depends on the caught strap
  spl_addr_filter u_addr (
    .clk          (clk),
    .rstn         (rstn),
    .query_valid  (query_valid),
    .query_addr   (query_addr),
    .own_addr     (station_address_strap),
    .addr0_unique (addr0_unique),
    .hit          (addr_hit),
    .hit_bcast    (addr_hit_bcast)
  );

endmodule

// ===== tb/spl_top_sva.sv
// assertion checker for the strap pin latch
`timescale 1ns/1ps
module spl_top_sva
  import spl_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        isolate_strap,
  input wire logic        speed_strap,
  input wire logic        duplex_strap,
  input wire logic        autoneg_enable_strap,
  input wire logic        addr_zero_unique_strap,
  input wire logic        gate_chain_strap_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        query_valid,
  input wire logic [4:0]  query_addr,
  input wire logic [4:0]  station_address_strap,
  input wire logic        addr_hit,
  input wire logic        addr_hit_bcast,
  input wire logic        ctrl_isolate,
  input wire logic        ctrl_speed_100,
  input wire logic        ctrl_full_duplex,
  input wire logic        ctrl_autoneg_en,
  input wire logic [3:0]  adv_ability,
  input wire logic        gate_chain_test_en,
  input wire logic        straps_loaded
);
  logic [2:0] cnt;
  spl_strap_t snap;
  logic       ld;

  // ----------------------------------------
  // cycle count since release and pin shadow
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 3'h0;
    end else if (cnt != 3'h7) begin
      cnt <= cnt + 3'h1;
    end
  end
  // pins as seen at the first edge after release
  always_ff @(posedge clk) begin
    if (rstn && cnt == 3'h0) begin
      snap <= {isolate_strap, speed_strap, duplex_strap, autoneg_enable_strap,
               addr_zero_unique_strap, gate_chain_strap_n};
    end
  end
  assign ld = (cnt == 3'h4);

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_load_edge;
    cnt == 3'h3 |-> !straps_loaded ##1 straps_loaded;
  endproperty
  property p_iso;
    ld |-> ctrl_isolate == snap.isolate;
  endproperty
  property p_speed;
    ld |-> ctrl_speed_100 == snap.speed;
  endproperty
  property p_adv;
    ld |-> adv_ability == (snap.speed ? 4'hF : 4'h3);
  endproperty
  property p_dup;
    ld |-> ctrl_full_duplex == !snap.duplex_half;
  endproperty
  property p_an;
    ld |-> ctrl_autoneg_en == snap.autoneg;
  endproperty
  property p_gate;
    ld |-> gate_chain_test_en == !snap.gate_chain_n;
  endproperty
  property p_gate_hold;
    straps_loaded && $past(straps_loaded) |-> $stable(gate_chain_test_en);
  endproperty
  property p_bcast;
    query_valid && query_addr == 5'h00 && straps_loaded && !snap.addr0_unique
      |=> addr_hit && addr_hit_bcast;
  endproperty
  property p_unique;
    query_valid && query_addr == 5'h00 && straps_loaded && snap.addr0_unique
      |=> !addr_hit_bcast && addr_hit == ($past(station_address_strap) == 5'h00);
  endproperty
  property p_seed;
    reg_wr && reg_addr == 8'h00 && !reg_wdata[15] && cnt == 3'h7
      |=> ctrl_isolate == $past(reg_wdata[10]) && ctrl_speed_100 == $past(reg_wdata[13]);
  endproperty

  a_load_edge: assert property (p_load_edge) else $error("load not at fourth edge");
  a_iso: assert property (p_iso) else $error("isolate not seeded");
  a_speed: assert property (p_speed) else $error("speed not seeded");
  a_adv: assert property (p_adv) else $error("advert not seeded");
  a_dup: assert property (p_dup) else $error("duplex not seeded");
  a_an: assert property (p_an) else $error("autoneg not seeded");
  a_gate: assert property (p_gate) else $error("gate chain wrong");
  a_gate_hold: assert property (p_gate_hold) else $error("gate chain moved");
  a_bcast: assert property (p_bcast) else $error("zero not broadcast");
  a_unique: assert property (p_unique) else $error("zero not unique");
  a_seed: assert property (p_seed) else $error("write not applied");

  c_load: cover property (ld && straps_loaded);
  c_bcast: cover property (addr_hit_bcast);
  c_unique: cover property (query_valid && query_addr == 5'h00 && snap.addr0_unique ##1 addr_hit);
endmodule

// ===== tb/spl_strap_board.sv
// board model: strap resistors, then pins reused as outputs
`timescale 1ns/1ps
`include "spl_map.svh"
module spl_strap_board
  import spl_pkg::*;
(
  input  wire logic       clk,
  input  wire spl_strap_t level,
  input  wire logic       fitted,
  input  wire logic       wiggle,
  output spl_strap_t      pins
);
  logic [5:0] walk = 6'h2A;

  // pattern that changes every cycle once the pins turn to outputs
  always_ff @(posedge clk) begin
    walk <= walk + 6'h15;
  end
  // no resistor fitted leaves the weak pulls in charge
  always_comb begin
    if (wiggle) begin
      pins = level ^ walk;
    end else if (fitted) begin
      pins = level;
    end else begin
      pins = `SPL_DEF_STRAPS;
    end
  end
endmodule

// ===== tb/spl_top_bench.sv
// self-checking bench for the strap pin latch
`timescale 1ns/1ps
`include "spl_map.svh"
module spl_top_bench
  import spl_pkg::*;
;
  logic        clk, rstn, reg_wr, reg_rd, query_valid, fitted, wiggle, an_restart;
  logic        addr_hit, addr_hit_bcast, straps_loaded, gate_chain_test_en;
  logic        ctrl_isolate, ctrl_speed_100, ctrl_full_duplex, ctrl_autoneg_en;
  logic        ctrl_loopback, ctrl_power_down;
  logic [7:0]  reg_addr, outs;
  logic [31:0] reg_wdata, reg_rdata;
  logic [4:0]  query_addr, station_address_strap;
  logic [3:0]  adv_ability;
  spl_strap_t  level, pins;
  int          mismatches, tests_run, cycles;

  spl_top i_spl_top (
    .clk, .rstn, .isolate_strap(pins.isolate), .speed_strap(pins.speed),
    .duplex_strap(pins.duplex_half), .autoneg_enable_strap(pins.autoneg),
    .addr_zero_unique_strap(pins.addr0_unique), .gate_chain_strap_n(pins.gate_chain_n),
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .query_valid, .query_addr,
    .station_address_strap, .addr_hit, .addr_hit_bcast, .ctrl_isolate, .ctrl_speed_100,
    .ctrl_full_duplex, .ctrl_autoneg_en, .ctrl_loopback, .ctrl_power_down, .an_restart,
    .adv_ability, .gate_chain_test_en, .straps_loaded
  );
  spl_strap_board i_spl_strap_board (.clk, .level, .fitted, .wiggle, .pins);

  assign outs = {ctrl_isolate, ctrl_speed_100, ctrl_full_duplex, ctrl_autoneg_en,
                 ctrl_loopback, ctrl_power_down, gate_chain_test_en, straps_loaded};

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      $display("mismatch at %0t: timeout", $time);
      end_of_test();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] exp_outs(spl_strap_t s);
    return {s.isolate, s.speed, !s.duplex_half, s.autoneg, 2'b00, !s.gate_chain_n, 1'b1};
  endfunction
  function automatic logic [31:0] exp_ctrl(spl_strap_t s);
    return {18'h0, s.speed, s.autoneg, 1'b0, s.isolate, 1'b0, !s.duplex_half, 8'h00};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, what);
  endtask
  task automatic ask(input logic [4:0] a, input logic [1:0] exp);
    @(posedge clk);
    query_valid <= 1'b1;
    query_addr  <= a;
    @(posedge clk);
    query_valid <= 1'b0;
    #1;
    chk({addr_hit, addr_hit_bcast}, exp, "query");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // one reset, strap load and software pass
  // ----------------------------------------
  task automatic run_case(input int i);
    spl_strap_t  s, eff;
    logic [4:0]  q;
    logic [31:0] w;
    logic [3:0]  a;
    s = (i == 1) ? ~spl_strap_t'(`SPL_DEF_STRAPS) : spl_strap_t'(6'($urandom));
    if (i == 2) begin
      s.addr0_unique = 1'b1;
    end
    eff = (i != 0) ? s : spl_strap_t'(`SPL_DEF_STRAPS);
    @(posedge clk);
    rstn                  <= 1'b0;
    wiggle                <= 1'b0;
    fitted                <= (i != 0);
    level                 <= s;
    station_address_strap <= (i == 2) ? 5'h00 : 5'($urandom_range(31, 1));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    wiggle <= 1'b1;
    #1;
    chk(outs, exp_outs(eff), "outputs");
    rd(`SPL_OFS_CTRL, exp_ctrl(eff), "control");
    rd(`SPL_OFS_ADV, {23'h0, (eff.speed ? 4'hF : 4'h3), 5'h01}, "advert");
    rd(`SPL_OFS_STAT, {24'h0, eff[5:2], 4'hA}, "status");
    rd(8'h0C, 32'h0, "unmapped");
    ask(5'h00, {!eff.addr0_unique | (station_address_strap == 5'h00), !eff.addr0_unique});
    q = i[0] ? station_address_strap : 5'($urandom_range(31, 1));
    ask(q, {q == station_address_strap, 1'b0});
    w = $urandom & 32'hFFFF7FFF;
    wr(`SPL_OFS_CTRL, w);
    chk(outs, {w[10], w[13], w[8], w[12], w[14], w[11], !eff.gate_chain_n, 1'b1}, "written");
    chk(an_restart, w[9], "restart");
    rd(`SPL_OFS_CTRL, w & 32'h7D00, "readback");
    // read data must fall back to zero once the read cycle is over
    @(posedge clk);
    #1;
    chk(reg_rdata, 32'h0, "read data cleared");
    // software rewrites the advertised abilities
    a = ~w[3:0];
    wr(`SPL_OFS_ADV, {23'h0, a, 5'h00});
    chk(adv_ability, a, "advert written");
    // reload puts back the frozen snapshot while the pins wiggle
    wr(`SPL_OFS_CTRL, 32'h0000_8000);
    @(posedge clk);
    #1;
    chk(outs, exp_outs(eff), "reload");
    rd(`SPL_OFS_ADV, {23'h0, (eff.speed ? 4'hF : 4'h3), 5'h01}, "advert reload");
  endtask

  initial begin
    rstn                  = 1'b0;
    reg_wr                = 1'b0;
    reg_rd                = 1'b0;
    reg_addr              = 8'h00;
    reg_wdata             = 32'h0;
    query_valid           = 1'b0;
    query_addr            = 5'h00;
    station_address_strap = 5'h01;
    level                 = `SPL_DEF_STRAPS;
    fitted                = 1'b0;
    wiggle                = 1'b0;
    mismatches            = 0;
    tests_run             = 0;
    cycles                = 0;
    void'($urandom(32'h5b382323));
    for (int i = 0; i < 8; i++) begin
      run_case(i);
    end
    end_of_test();
  end
endmodule

bind spl_top spl_top_sva i_spl_top_sva (
  .clk, .rstn, .isolate_strap, .speed_strap, .duplex_strap, .autoneg_enable_strap,
  .addr_zero_unique_strap, .gate_chain_strap_n, .reg_addr, .reg_wdata, .reg_wr,
  .query_valid, .query_addr, .station_address_strap, .addr_hit, .addr_hit_bcast,
  .ctrl_isolate, .ctrl_speed_100, .ctrl_full_duplex, .ctrl_autoneg_en, .adv_ability,
  .gate_chain_test_en, .straps_loaded
);
